// ===== hdl/motion_option_decoder.sv
// Purpose: decode option and monitor selection fields of a command frame
// Assumes: frame fields and parameters come from logic on CLOCK_I
// Notes: results appear one edge after FRAME_VALID_I and hold
`timescale 1ns/1ps
module motion_option_decoder
	import motion_option_pkg::*;
(
	input wire logic CLOCK_I, // 40 MHz clock
	input wire logic RESET_N_I, // Async reset, active low
	input wire logic FRAME_VALID_I, // One-cycle frame strobe
	input wire logic [7:0] COMMAND_CODE_I, // Command byte
	input wire logic [15:0] OPTION_FIELD_I, // Bytes three, four
	input wire logic [15:0] MONITOR_SELECT_I, // Two selection bytes
	input wire logic [15:0] OPTION_ALLOC_MODE_PARAM_I, // Mode digit
	input wire logic [15:0] OPTION_ALLOC_PARAM_FIRST_I, // Filter, gain
	input wire logic [15:0] OPTION_ALLOC_PARAM_2_I, // Speed, clear
	input wire logic [15:0] OPTION_ALLOC_PARAM_3_I, // Torque limits
	input wire logic [15:0] OPTION_ALLOC_PARAM_4_I, // Latch, bank
	input wire logic [15:0] OPTION_ALLOC_PARAM_LAST_I, // Outputs
	input wire logic [15:0] OUTPUT_ASSIGN_PARAM_A_I, // Output 1 assign
	input wire logic [15:0] OUTPUT_ASSIGN_PARAM_B_I, // Output 2 assign
	input wire logic [15:0] OUTPUT_ASSIGN_PARAM_C_I, // Output 3 assign
	output logic FRAME_DONE_O, // Frame decoded pulse
	output logic OPTION_APPLIED_O, // Option decoded pulse
	output logic ALLOC_CUSTOM_O, // Custom map in use
	output logic [1:0] ACCEL_FILTER_SELECT_O, // Filter code
	output logic ACCEL_FILTER_INVALID_O, // Code 3 received
	output logic GAIN_SECOND_O, // Second gain set
	output logic GAIN_SELECT_INVALID_O, // Reserved gain code
	output logic SPEED_LOOP_P_ONLY_O, // P-only speed loop
	output logic POSITION_INTEGRATOR_CLEAR_O, // Clear integrator
	output logic FORWARD_TORQUE_LIMIT_EN_O, // Forward limit
	output logic REVERSE_TORQUE_LIMIT_EN_O, // Reverse limit
	output logic LATCH_INPUT_BLOCK_O, // Latch input blocked
	output logic [3:0] ACCEL_PARAM_BANK_O, // Bank 0 to 15
	output logic GENERAL_OUTPUT_1_O, // General output 1
	output logic GENERAL_OUTPUT_2_O, // General output 2
	output logic GENERAL_OUTPUT_3_O, // General output 3
	output logic [3:0] MONITOR_CODE_1_O, // Slot 1 code
	output logic [3:0] MONITOR_CODE_2_O, // Slot 2 code
	output logic [3:0] MONITOR_CODE_3_O, // Slot 3 code
	output logic [3:0] MONITOR_CODE_4_O, // Slot 4 code
	output logic [2:0] MONITOR_CLASS_1_O, // Slot 1 class
	output logic [2:0] MONITOR_CLASS_2_O, // Slot 2 class
	output logic [2:0] MONITOR_CLASS_3_O, // Slot 3 class
	output logic [2:0] MONITOR_CLASS_4_O // Slot 4 class
);

	typedef struct packed {
		logic loaded;
		logic alloc_custom;
		logic [NUM_ALLOC_PARAMS-1:0][15:0] alloc;
		logic frame_done;
		logic option_applied;
		logic [1:0] accel_filter_select;
		logic accel_filter_invalid;
		logic gain_second;
		logic gain_select_invalid;
		logic speed_loop_p_only;
		logic position_integrator_clear;
		logic forward_torque_limit_en;
		logic reverse_torque_limit_en;
		logic latch_input_block;
		logic [3:0] accel_param_bank;
		logic [2:0] general_output;
		logic [3:0][3:0] monitor_code_select;
	} decoder_state_t;

	localparam logic [NUM_ALLOC_PARAMS-1:0][15:0] DEFAULT_ALLOC = {
		DEFAULT_ALLOC_4, DEFAULT_ALLOC_3, DEFAULT_ALLOC_2,
		DEFAULT_ALLOC_1, DEFAULT_ALLOC_0
	};

	decoder_state_t st;
	decoder_state_t next_st;
	logic rst_meta_n;
	logic rst_n;
	logic [NUM_ALLOC_PARAMS-1:0][15:0] active_alloc;
	logic [3:0] filter_bits;
	logic [3:0] gain_bits;
	logic [3:0] speed_bits;
	logic [3:0] clear_bits;
	logic [3:0] fwd_bits;
	logic [3:0] rev_bits;
	logic [3:0] latch_bits;
	logic [3:0] bank_bits;
	logic [3:0] out_bits;
	logic outputs_free;
	logic option_cmd;
	logic monitor_cmd;
	logic config_cmd;
	logic [2:0] class_1;
	logic [2:0] class_2;
	logic [2:0] class_3;
	logic [2:0] class_4;
	logic [7:0] filter_alloc;
	logic [7:0] gain_alloc;
	logic [7:0] speed_alloc;
	logic [7:0] clear_alloc;
	logic [7:0] fwd_alloc;
	logic [7:0] rev_alloc;
	logic [7:0] latch_alloc;
	logic [7:0] bank_alloc;
	logic [7:0] out_alloc;
	logic option_frame;
	logic monitor_frame;
	logic config_frame;

	// Picks up to four option bits from a start position, wrapping at 16
	function automatic logic [3:0] pick_bits(
		input logic [15:0] field,
		input logic [7:0] alloc_byte
	);
		logic [3:0] start;
		logic [31:0] twice;
		start = alloc_byte[ALLOC_POS_LSB +: 4];
		// Doubled field turns a wrap past bit 15 into a plain shift
		twice = {field, field} >> start;
		if (alloc_byte[ALLOC_EN_BIT])
			pick_bits = twice[3:0];
		else
			pick_bits = 4'h0;
	endfunction

	// Release of the external reset through two flops
	always_ff @(posedge CLOCK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			rst_meta_n <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta_n <= 1'b1;
			rst_n <= rst_meta_n;
		end
	end

	// Command classification
	always_comb
	begin
		option_cmd = takes_option(COMMAND_CODE_I);
		monitor_cmd = takes_monitor(COMMAND_CODE_I);
		config_cmd = (COMMAND_CODE_I == CMD_CONFIG);
		option_frame = FRAME_VALID_I && option_cmd;
		monitor_frame = FRAME_VALID_I && monitor_cmd;
		config_frame = FRAME_VALID_I && config_cmd;
	end

	// Latched map, never the live parameters
	always_comb
	begin
		if (st.alloc_custom)
			active_alloc = st.alloc;
		else
			active_alloc = DEFAULT_ALLOC;
	end

	// One byte per function, in the order the parameters carry them
	always_comb
	begin
		filter_alloc = active_alloc[0][7:0];
		gain_alloc = active_alloc[0][15:8];
		speed_alloc = active_alloc[1][7:0];
		clear_alloc = active_alloc[1][15:8];
		fwd_alloc = active_alloc[2][7:0];
		rev_alloc = active_alloc[2][15:8];
		latch_alloc = active_alloc[3][7:0];
		bank_alloc = active_alloc[3][15:8];
		out_alloc = active_alloc[4][7:0];
	end

	// Function extraction from the option field
	always_comb
	begin
		filter_bits = pick_bits(OPTION_FIELD_I, filter_alloc);
		gain_bits = pick_bits(OPTION_FIELD_I, gain_alloc);
		speed_bits = pick_bits(OPTION_FIELD_I, speed_alloc);
		clear_bits = pick_bits(OPTION_FIELD_I, clear_alloc);
		fwd_bits = pick_bits(OPTION_FIELD_I, fwd_alloc);
		rev_bits = pick_bits(OPTION_FIELD_I, rev_alloc);
		latch_bits = pick_bits(OPTION_FIELD_I, latch_alloc);
		bank_bits = pick_bits(OPTION_FIELD_I, bank_alloc);
		out_bits = pick_bits(OPTION_FIELD_I, out_alloc);
	end

	// Outputs are owned by the option field only when unassigned
	always_comb
	begin
		outputs_free = (OUTPUT_ASSIGN_PARAM_A_I == 16'h0000)
			&& (OUTPUT_ASSIGN_PARAM_B_I == 16'h0000)
			&& (OUTPUT_ASSIGN_PARAM_C_I == 16'h0000);
	end

	always_comb
	begin
		next_st = st;
		next_st.frame_done = 1'b0;
		next_st.option_applied = 1'b0;

		// Map is captured once after reset and on each configuration
		if (!st.loaded || config_frame)
		begin
			next_st.loaded = 1'b1;
			next_st.alloc_custom =
				(OPTION_ALLOC_MODE_PARAM_I[3:0] == ALLOC_MODE_CUSTOM);
			next_st.alloc = {
				OPTION_ALLOC_PARAM_LAST_I, OPTION_ALLOC_PARAM_4_I,
				OPTION_ALLOC_PARAM_3_I, OPTION_ALLOC_PARAM_2_I,
				OPTION_ALLOC_PARAM_FIRST_I
			};
		end

		if (FRAME_VALID_I)
		begin
			next_st.frame_done = 1'b1;
			if (option_frame)
			begin
				next_st.option_applied = 1'b1;
				// Illegal filter code falls back to no filter
				if (filter_bits[1:0] == FILTER_ILLEGAL)
				begin
					next_st.accel_filter_select = FILTER_NONE;
					next_st.accel_filter_invalid = 1'b1;
				end
				else
				begin
					next_st.accel_filter_select = filter_bits[1:0];
					next_st.accel_filter_invalid = 1'b0;
				end
				// Reserved gain codes keep the first gain set
				unique case (gain_bits[1:0])
					GAIN_FIRST:
					begin
						next_st.gain_second = 1'b0;
						next_st.gain_select_invalid = 1'b0;
					end
					GAIN_SECOND:
					begin
						next_st.gain_second = 1'b1;
						next_st.gain_select_invalid = 1'b0;
					end
					default:
					begin
						next_st.gain_second = 1'b0;
						next_st.gain_select_invalid = 1'b1;
					end
				endcase
				next_st.speed_loop_p_only = speed_bits[0];
				next_st.position_integrator_clear = clear_bits[0];
				next_st.forward_torque_limit_en = fwd_bits[0];
				next_st.reverse_torque_limit_en = rev_bits[0];
				next_st.latch_input_block = latch_bits[0];
				next_st.accel_param_bank = bank_bits;
				// Assigned outputs belong to other sources, so stay off
				if (outputs_free)
				begin
					next_st.general_output[0] = out_bits[0];
					next_st.general_output[1] = out_bits[1];
					next_st.general_output[2] = out_bits[2];
				end
				else
					next_st.general_output = 3'h0;
			end
			if (monitor_frame)
			begin
				next_st.monitor_code_select[0] =
					MONITOR_SELECT_I[3:0];
				next_st.monitor_code_select[1] =
					MONITOR_SELECT_I[7:4];
				next_st.monitor_code_select[2] =
					MONITOR_SELECT_I[11:8];
				next_st.monitor_code_select[3] =
					MONITOR_SELECT_I[15:12];
			end
		end
	end

	always_ff @(posedge CLOCK_I or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st <= '0;
			st.monitor_code_select <= {4{MON_CODE_RESET}};
		end
		else
			st <= next_st;
	end

	// Tables look up the next codes so classes line up with the codes
	monitor_code_table u_class_1 (
		.clk_i(CLOCK_I),
		.rst_n_i(rst_n),
		.code_i(next_st.monitor_code_select[0]),
		.class_o(class_1)
	);

	monitor_code_table u_class_2 (
		.clk_i(CLOCK_I),
		.rst_n_i(rst_n),
		.code_i(next_st.monitor_code_select[1]),
		.class_o(class_2)
	);

	monitor_code_table u_class_3 (
		.clk_i(CLOCK_I),
		.rst_n_i(rst_n),
		.code_i(next_st.monitor_code_select[2]),
		.class_o(class_3)
	);

	monitor_code_table u_class_4 (
		.clk_i(CLOCK_I),
		.rst_n_i(rst_n),
		.code_i(next_st.monitor_code_select[3]),
		.class_o(class_4)
	);

	assign FRAME_DONE_O = st.frame_done;
	assign OPTION_APPLIED_O = st.option_applied;
	assign ALLOC_CUSTOM_O = st.alloc_custom;
	assign ACCEL_FILTER_SELECT_O = st.accel_filter_select;
	assign ACCEL_FILTER_INVALID_O = st.accel_filter_invalid;
	assign GAIN_SECOND_O = st.gain_second;
	assign GAIN_SELECT_INVALID_O = st.gain_select_invalid;
	assign SPEED_LOOP_P_ONLY_O = st.speed_loop_p_only;
	assign POSITION_INTEGRATOR_CLEAR_O = st.position_integrator_clear;
	assign FORWARD_TORQUE_LIMIT_EN_O = st.forward_torque_limit_en;
	assign REVERSE_TORQUE_LIMIT_EN_O = st.reverse_torque_limit_en;
	assign LATCH_INPUT_BLOCK_O = st.latch_input_block;
	assign ACCEL_PARAM_BANK_O = st.accel_param_bank;
	assign GENERAL_OUTPUT_1_O = st.general_output[0];
	assign GENERAL_OUTPUT_2_O = st.general_output[1];
	assign GENERAL_OUTPUT_3_O = st.general_output[2];
	assign MONITOR_CODE_1_O = st.monitor_code_select[0];
	assign MONITOR_CODE_2_O = st.monitor_code_select[1];
	assign MONITOR_CODE_3_O = st.monitor_code_select[2];
	assign MONITOR_CODE_4_O = st.monitor_code_select[3];
	assign MONITOR_CLASS_1_O = class_1;
	assign MONITOR_CLASS_2_O = class_2;
	assign MONITOR_CLASS_3_O = class_3;
	assign MONITOR_CLASS_4_O = class_4;

endmodule // motion_option_decoder

// ===== hdl/motion_option_pkg.sv
// Purpose: constants for the motion option and monitor selection decoder
// Assumes: one 40 MHz command-processing clock
// Notes: command codes and allocation byte layout are local choices
// Summary of operation
// - Option field is frame bytes three and four
// - Options honoured only for option-taking motion commands
// - Default bit map unless allocation mode digit is 1
// - New allocation applies after reset or configuration
// - Two-bit filter select: none, exponential, S-curve
// - Two-bit gain select; codes two, three invalid
// - Speed loop bit: PI or P-only
// - Position integrator clear bit
// - Forward and reverse torque limit enables
// - Latch input block bit, allocated only
// - Four-bit acceleration parameter bank select
// - Three bits drive general outputs directly
// - General outputs need all assignment parameters zero
// - Unallocated function reads as zero
// - Monitor selection accepted with monitor and motion commands except CMD_SV_CTRL
// - Four monitor nibbles over two bytes
// - Monitor codes map to position, speed, torque, option
package motion_option_pkg;

	// Command codes
	localparam logic [7:0] CMD_CONFIG = 8'h04;
	localparam logic [7:0] CMD_SMON = 8'h30;
	localparam logic [7:0] CMD_SV_ON = 8'h31;
	localparam logic [7:0] CMD_SV_OFF = 8'h32;
	localparam logic [7:0] CMD_HOLD = 8'h25;
	localparam logic [7:0] CMD_INTERPOLATE = 8'h34;
	localparam logic [7:0] CMD_POSING = 8'h35;
	localparam logic [7:0] CMD_FEED = 8'h36;
	localparam logic [7:0] CMD_LATCH = 8'h38;
	localparam logic [7:0] CMD_EX_POSING = 8'h39;
	localparam logic [7:0] CMD_HOMING = 8'h3a;
	localparam logic [7:0] CMD_SPEED = 8'h3c;
	localparam logic [7:0] CMD_TORQUE = 8'h3d;
	localparam logic [7:0] CMD_SV_CTRL = 8'h3f;
	localparam logic [7:0] CMD_SENS_ON = 8'h23;
	localparam logic [7:0] CMD_SENS_OFF = 8'h24;
	localparam logic [7:0] CMD_BRK_ON = 8'h21;
	localparam logic [7:0] CMD_BRK_OFF = 8'h22;
	localparam logic [7:0] CMD_LTMOD_ON = 8'h28;
	localparam logic [7:0] CMD_LTMOD_OFF = 8'h29;

	// Allocation byte: start bit in [3:0], enable in [4]
	localparam int ALLOC_POS_LSB = 0;
	localparam int ALLOC_EN_BIT = 4;
	localparam logic [3:0] ALLOC_MODE_CUSTOM = 4'h1;
	localparam int NUM_ALLOC_PARAMS = 5;
	localparam logic [15:0] DEFAULT_ALLOC_0 = 16'h1813;
	localparam logic [15:0] DEFAULT_ALLOC_1 = 16'h1d1c;
	localparam logic [15:0] DEFAULT_ALLOC_2 = 16'h1f1e;
	localparam logic [15:0] DEFAULT_ALLOC_3 = 16'h0000;
	localparam logic [15:0] DEFAULT_ALLOC_4 = 16'h0000;

	// Filter and gain codes
	localparam logic [1:0] FILTER_NONE = 2'h0;
	localparam logic [1:0] FILTER_ILLEGAL = 2'h3;
	localparam logic [1:0] GAIN_FIRST = 2'h0;
	localparam logic [1:0] GAIN_SECOND = 2'h1;

	// Monitor slot classes
	localparam logic [2:0] MON_UNUSED = 3'h0;
	localparam logic [2:0] MON_POSITION = 3'h1;
	localparam logic [2:0] MON_SPEED = 3'h2;
	localparam logic [2:0] MON_TORQUE = 3'h3;
	localparam logic [2:0] MON_OPTION = 3'h4;
	localparam logic [3:0] MON_CODE_RESET = 4'h0;

	function automatic logic takes_option(input logic [7:0] code);
		takes_option = (code == CMD_SV_ON) || (code == CMD_HOLD)
			|| (code == CMD_INTERPOLATE) || (code == CMD_POSING)
			|| (code == CMD_FEED) || (code == CMD_LATCH)
			|| (code == CMD_EX_POSING) || (code == CMD_HOMING)
			|| (code == CMD_SPEED) || (code == CMD_TORQUE)
			|| (code == CMD_SV_CTRL);
	endfunction

	function automatic logic takes_monitor(input logic [7:0] code);
		takes_monitor = (takes_option(code) && code != CMD_SV_CTRL)
			|| (code == CMD_SV_OFF) || (code == CMD_SMON)
			|| (code == CMD_SENS_ON) || (code == CMD_SENS_OFF)
			|| (code == CMD_BRK_ON) || (code == CMD_BRK_OFF)
			|| (code == CMD_LTMOD_ON) || (code == CMD_LTMOD_OFF);
	endfunction

endpackage

// ===== hdl/monitor_code_table.sv
// Purpose: lookup of the quantity class for one monitor code
// Assumes: address settles before the clock edge
// Notes: read data is registered
`timescale 1ns/1ps
module monitor_code_table
	import motion_option_pkg::*;
(
	input wire logic clk_i, // Clock
	input wire logic rst_n_i, // Synchronised reset
	input wire logic [3:0] code_i, // Monitor code
	output logic [2:0] class_o // Quantity class
);

	typedef struct packed {
		logic [2:0] class_q;
	} table_state_t;

	table_state_t st;
	table_state_t next_st;

	always_comb
	begin
		next_st = st;
		unique case (code_i)
			4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6:
				next_st.class_q = MON_POSITION;
			4'h8, 4'h9, 4'ha: next_st.class_q = MON_SPEED;
			4'hb: next_st.class_q = MON_TORQUE;
			4'he, 4'hf: next_st.class_q = MON_OPTION;
			4'h7, 4'hc, 4'hd: next_st.class_q = MON_UNUSED;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			st <= '0;
		else
			st <= next_st;
	end

	assign class_o = st.class_q;

endmodule // monitor_code_table

// ===== testbench/motion_option_decoder_checker.sv
// Purpose: port-level assertions for the option decoder
// Assumes: frames strobed on CLOCK_I, reset active low
// Notes: default-map checks are gated by ALLOC_CUSTOM_O
`timescale 1ns/1ps
module motion_option_decoder_checker
	import motion_option_pkg::*;
(
	input wire logic CLOCK_I, // Clock
	input wire logic RESET_N_I, // Reset
	input wire logic FRAME_VALID_I, // Strobe
	input wire logic [7:0] COMMAND_CODE_I, // Command
	input wire logic [15:0] OPTION_FIELD_I, // Options
	input wire logic [15:0] MONITOR_SELECT_I, // Monitors
	input wire logic [15:0] OUTPUT_ASSIGN_PARAM_A_I, // Assign 1
	input wire logic FRAME_DONE_O, // Done
	input wire logic OPTION_APPLIED_O, // Applied
	input wire logic ALLOC_CUSTOM_O, // Custom map
	input wire logic [1:0] ACCEL_FILTER_SELECT_O, // Filter
	input wire logic GAIN_SECOND_O, // Gain
	input wire logic SPEED_LOOP_P_ONLY_O, // P-only
	input wire logic POSITION_INTEGRATOR_CLEAR_O, // Clear
	input wire logic FORWARD_TORQUE_LIMIT_EN_O, // Fwd
	input wire logic REVERSE_TORQUE_LIMIT_EN_O, // Rev
	input wire logic GENERAL_OUTPUT_1_O, // Output 1
	input wire logic [3:0] MONITOR_CODE_1_O, // Slot 1
	input wire logic [3:0] MONITOR_CODE_2_O, // Slot 2
	input wire logic [3:0] MONITOR_CODE_3_O, // Slot 3
	input wire logic [3:0] MONITOR_CODE_4_O // Slot 4
);
	default clocking cb @(posedge CLOCK_I);
	endclocking
	default disable iff (!RESET_N_I);
	logic pos;
	logic smon;
	assign pos = FRAME_VALID_I && COMMAND_CODE_I == CMD_POSING;
	assign smon = FRAME_VALID_I && COMMAND_CODE_I == CMD_SMON;
	AST_DONE: assert property (!FRAME_VALID_I |=> !FRAME_DONE_O)
		else $error("done pulse without frame");
	AST_APPLIED: assert property (pos |=> OPTION_APPLIED_O && FRAME_DONE_O)
		else $error("option command not applied");
	AST_HOLD: assert property (smon |=> !OPTION_APPLIED_O
		&& $stable(ACCEL_FILTER_SELECT_O) && $stable(GAIN_SECOND_O))
		else $error("option values moved on monitor command");
	AST_FILT: assert property (pos && !ALLOC_CUSTOM_O |=>
		ACCEL_FILTER_SELECT_O == ($past(OPTION_FIELD_I[4:3]) == 2'h3 ?
		2'h0 : $past(OPTION_FIELD_I[4:3])))
		else $error("filter select wrong");
	AST_GAIN: assert property (pos && !ALLOC_CUSTOM_O |=>
		GAIN_SECOND_O == ($past(OPTION_FIELD_I[9:8]) == 2'h1))
		else $error("gain select wrong");
	AST_LOOP: assert property (pos && !ALLOC_CUSTOM_O |=>
		{REVERSE_TORQUE_LIMIT_EN_O, FORWARD_TORQUE_LIMIT_EN_O,
		POSITION_INTEGRATOR_CLEAR_O, SPEED_LOOP_P_ONLY_O}
		== $past(OPTION_FIELD_I[15:12]))
		else $error("loop or limit bits wrong");
	AST_MON: assert property (smon |=> {MONITOR_CODE_4_O,
		MONITOR_CODE_3_O, MONITOR_CODE_2_O, MONITOR_CODE_1_O}
		== $past(MONITOR_SELECT_I))
		else $error("monitor codes wrong");
	AST_OUT: assert property (pos && OUTPUT_ASSIGN_PARAM_A_I != 16'h0000
		|=> !GENERAL_OUTPUT_1_O)
		else $error("general output driven while assigned");
endmodule // motion_option_decoder_checker

bind motion_option_decoder motion_option_decoder_checker chk (
	.CLOCK_I(CLOCK_I), .RESET_N_I(RESET_N_I),
	.FRAME_VALID_I(FRAME_VALID_I), .COMMAND_CODE_I(COMMAND_CODE_I),
	.OPTION_FIELD_I(OPTION_FIELD_I), .MONITOR_SELECT_I(MONITOR_SELECT_I),
	.OUTPUT_ASSIGN_PARAM_A_I(OUTPUT_ASSIGN_PARAM_A_I),
	.FRAME_DONE_O(FRAME_DONE_O), .OPTION_APPLIED_O(OPTION_APPLIED_O),
	.ALLOC_CUSTOM_O(ALLOC_CUSTOM_O),
	.ACCEL_FILTER_SELECT_O(ACCEL_FILTER_SELECT_O),
	.GAIN_SECOND_O(GAIN_SECOND_O), .SPEED_LOOP_P_ONLY_O(SPEED_LOOP_P_ONLY_O),
	.POSITION_INTEGRATOR_CLEAR_O(POSITION_INTEGRATOR_CLEAR_O),
	.FORWARD_TORQUE_LIMIT_EN_O(FORWARD_TORQUE_LIMIT_EN_O),
	.REVERSE_TORQUE_LIMIT_EN_O(REVERSE_TORQUE_LIMIT_EN_O),
	.GENERAL_OUTPUT_1_O(GENERAL_OUTPUT_1_O),
	.MONITOR_CODE_1_O(MONITOR_CODE_1_O), .MONITOR_CODE_2_O(MONITOR_CODE_2_O),
	.MONITOR_CODE_3_O(MONITOR_CODE_3_O), .MONITOR_CODE_4_O(MONITOR_CODE_4_O)
);

// ===== testbench/host_frame_model.sv
// Purpose: host controller placing frame fields onto the decoder
// Assumes: fields change at the falling clock edge
// Notes: idle fields show inverted last values, never stale ones
`timescale 1ns/1ps
module host_frame_model
(
	input wire logic clk_i, // Clock
	output logic frame_valid_o, // Strobe
	output logic [7:0] command_code_o, // Command
	output logic [15:0] option_field_o, // Options
	output logic [15:0] monitor_select_o // Monitors
);
	logic [7:0] frame [0:15];
	initial
	begin
		frame_valid_o = 1'b0;
		command_code_o = 8'h00;
		option_field_o = 16'h0000;
		monitor_select_o = 16'h0000;
	end
	task automatic send(input logic [7:0] c, input logic [15:0] o,
		input logic [15:0] m);
		@(negedge clk_i);
		frame[0] = c;
		frame[2] = o[7:0];
		frame[3] = o[15:8];
		frame[12] = m[7:0];
		frame[13] = m[15:8];
		command_code_o = frame[0];
		option_field_o = {frame[3], frame[2]};
		monitor_select_o = {frame[13], frame[12]};
		frame_valid_o = 1'b1;
	endtask
	task automatic idle();
		@(negedge clk_i);
		frame_valid_o = 1'b0;
		command_code_o = ~command_code_o;
		option_field_o = ~option_field_o;
		monitor_select_o = ~monitor_select_o;
	endtask
endmodule // host_frame_model

// ===== testbench/motion_option_decoder_tb.sv
// Purpose: self-checking bench for the option decoder
// Assumes: one answer edge per frame, class on the same edge
// Notes: custom map is fixed so that no two functions share a bit
`timescale 1ns/1ps
module motion_option_decoder_tb
	import motion_option_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n, fv, done, applied, custom, finv, gs, ginv, ponly, clr;
	logic fwd, rev, lat, o1, o2, o3;
	logic [1:0] filt;
	logic [2:0] c1, c2, c3, c4;
	logic [3:0] bank, m1, m2, m3, m4;
	logic [7:0] cmd;
	logic [15:0] opt, mon, mode, p1, p2, p3, p4, p5, oa, ob, oc;
	int mismatches = 0;
	int n_checks = 0;
	logic [7:0] cmds [19] = '{CMD_SV_ON, CMD_HOLD, CMD_INTERPOLATE,
		CMD_POSING, CMD_FEED, CMD_LATCH, CMD_EX_POSING, CMD_HOMING,
		CMD_SPEED, CMD_TORQUE, CMD_SV_CTRL, CMD_SV_OFF, CMD_SMON,
		CMD_SENS_ON, CMD_SENS_OFF, CMD_BRK_ON, CMD_BRK_OFF, CMD_LTMOD_ON,
		CMD_LTMOD_OFF};
	logic [2:0] cls [16] = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1,
		3'h0, 3'h2, 3'h2, 3'h2, 3'h3, 3'h0, 3'h0, 3'h4, 3'h4};
	always #12.5 clk = ~clk;
	host_frame_model h (.clk_i(clk), .frame_valid_o(fv),
		.command_code_o(cmd), .option_field_o(opt), .monitor_select_o(mon));
	motion_option_decoder DUT (.CLOCK_I(clk), .RESET_N_I(rst_n),
		.FRAME_VALID_I(fv), .COMMAND_CODE_I(cmd), .OPTION_FIELD_I(opt),
		.MONITOR_SELECT_I(mon), .OPTION_ALLOC_MODE_PARAM_I(mode),
		.OPTION_ALLOC_PARAM_FIRST_I(p1), .OPTION_ALLOC_PARAM_2_I(p2),
		.OPTION_ALLOC_PARAM_3_I(p3), .OPTION_ALLOC_PARAM_4_I(p4),
		.OPTION_ALLOC_PARAM_LAST_I(p5), .OUTPUT_ASSIGN_PARAM_A_I(oa),
		.OUTPUT_ASSIGN_PARAM_B_I(ob), .OUTPUT_ASSIGN_PARAM_C_I(oc),
		.FRAME_DONE_O(done), .OPTION_APPLIED_O(applied),
		.ALLOC_CUSTOM_O(custom), .ACCEL_FILTER_SELECT_O(filt),
		.ACCEL_FILTER_INVALID_O(finv), .GAIN_SECOND_O(gs),
		.GAIN_SELECT_INVALID_O(ginv), .SPEED_LOOP_P_ONLY_O(ponly),
		.POSITION_INTEGRATOR_CLEAR_O(clr), .FORWARD_TORQUE_LIMIT_EN_O(fwd),
		.REVERSE_TORQUE_LIMIT_EN_O(rev), .LATCH_INPUT_BLOCK_O(lat),
		.ACCEL_PARAM_BANK_O(bank), .GENERAL_OUTPUT_1_O(o1),
		.GENERAL_OUTPUT_2_O(o2), .GENERAL_OUTPUT_3_O(o3),
		.MONITOR_CODE_1_O(m1), .MONITOR_CODE_2_O(m2), .MONITOR_CODE_3_O(m3),
		.MONITOR_CODE_4_O(m4), .MONITOR_CLASS_1_O(c1),
		.MONITOR_CLASS_2_O(c2), .MONITOR_CLASS_3_O(c3),
		.MONITOR_CLASS_4_O(c4));
	function automatic logic [16:0] snap();
		snap = {filt, finv, gs, ginv, ponly, clr, fwd, rev, lat, bank, o1, o2,
			o3};
	endfunction
	task automatic chk(input string what, input logic [16:0] exp,
		input logic [16:0] got);
		n_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic fr(input logic [7:0] c, input logic [15:0] o,
		input logic [15:0] m);
		h.send(c, o, m);
		h.idle();
	endtask
	task automatic end_sim();
		if (mismatches == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge clk);
		mismatches++;
		end_sim();
	end
	initial
	begin
		rst_n = 1'b0;
		mode = 16'h0000;
		// Custom map waits behind mode 0 until a configuration frame
		p1 = 16'h1210;
		p2 = 16'h1514;
		p3 = 16'h1716;
		p4 = 16'h1918;
		p5 = 16'h001d;
		oa = 16'h0000;
		ob = 16'h0000;
		oc = 16'h0000;
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		chk("custom", 17'h0, {16'h0, custom});
		for (int k = 0; k < 4; k++)
		begin
			logic [1:0] i;
			i = 2'(k);
			fr(CMD_POSING, {{4{i[0]}}, 2'h0, i, 3'h0, i, 3'h0}, 16'h0);
			chk("done", 17'h1, {16'h0, done});
			chk("opts", {(i == 2'h3) ? 2'h0 : i, i == 2'h3, i == 2'h1, i[1],
				{4{i[0]}}, 8'h00}, snap());
		end
		for (int k = 0; k < 19; k++)
		begin
			h.send(CMD_POSING, 16'h0, 16'h0);
			fr(cmds[k], 16'h4008, 16'h8e31);
			chk("applied", {16'h0, k < 11}, {16'h0, applied});
			chk("opts", k < 11 ? 17'h08200 : 17'h0, snap());
			chk("mon", {1'h0, k != 10 ? 16'h8e31 : 16'h0},
				{1'h0, m4, m3, m2, m1});
		end
		for (int k = 0; k < 16; k++)
		begin
			fr(CMD_SMON, 16'h0, {4{4'(k)}});
			@(negedge clk);
			chk("class", {5'h0, {4{cls[k]}}}, {5'h0, c4, c3, c2, c1});
		end
		mode = 16'h0001;
		fr(CMD_POSING, 16'hffff, 16'h0);
		chk("opts", 17'h05f00, snap());
		fr(CMD_CONFIG, 16'h0, 16'h0);
		chk("custom", 17'h1, {16'h0, custom});
		fr(CMD_POSING, 16'hb556, 16'h0);
		chk("opts", 17'h12ad5, snap());
		oa = 16'h0001;
		fr(CMD_POSING, 16'hb556, 16'h0);
		chk("opts", 17'h12ad0, snap());
		// Reset stands in for a power cycle: map reloads on release
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		chk("custom", 17'h1, {16'h0, custom});
		fr(CMD_POSING, 16'hb556, 16'h0);
		chk("opts", 17'h12ad0, snap());
		end_sim();
	end
endmodule // motion_option_decoder_tb
